// file: core/ebrm_top.sv
// Purpose: Embedded block RAM with single, simple dual, true dual and packed modes
// Assumes: One core clock; per-port clock enables set each port's rate
// Notes: Mode, widths and read-during-write choices come from the APB control word
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module ebrm_top (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic device_wide_clear_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A
  input wire logic ce_a,
  input wire logic [12:0] addr_a,
  input wire logic [35:0] din_a,
  input wire logic we_a,
  input wire logic re_a,
  input wire logic stall_a = 1'b0,
  input wire logic aclr_a,
  output logic [35:0] q_a,
  // Port B
  input wire logic ce_b,
  input wire logic [12:0] addr_b,
  input wire logic [35:0] din_b,
  input wire logic we_b,
  input wire logic re_b,
  input wire logic stall_b = 1'b0,
  input wire logic aclr_b,
  output logic [35:0] q_b
);
  localparam int AW = ebrm_pkg::AW;
  localparam int DW = ebrm_pkg::DW;
  localparam int RW = ebrm_pkg::RW;
  localparam int LW = ebrm_pkg::LW;

  // Data bits carried by a port of the given shape
  function automatic int ebrm_width(logic [2:0] s, logic par);
    int w;
    if (s < 3'(ebrm_pkg::PAR_MIN)) begin
      w = 1 << s;
    end else begin
      w = (1 << (s - 3'(ebrm_pkg::PAR_MIN))) * (par ? LW : LW - 1);
    end
    return w;
  endfunction : ebrm_width

  // Row bit that user data bit j lands on; 36 or more means out of range
  function automatic int ebrm_idx(int j, logic [2:0] s, logic par, ebrm_pkg::ebrm_loc_t l);
    int ln;
    int b;
    if (s < 3'(ebrm_pkg::PAR_MIN)) begin
      ln = int'(l.lane);
      b = int'(l.off) + j;
    end else if (par) begin
      ln = int'(l.lane) + j / LW;
      b = j % LW;
    end else begin
      ln = int'(l.lane) + j / (LW - 1);
      b = j % (LW - 1);
    end
    return ln * LW + b;
  endfunction : ebrm_idx

  // Word address to row, byte lane and bit offset; narrow words share a lane
  function automatic ebrm_pkg::ebrm_loc_t ebrm_map(logic [AW-1:0] a, logic [2:0] s);
    ebrm_pkg::ebrm_loc_t l;
    int byte_i;
    int off_i;
    off_i = 0;
    if (s <= 3'(ebrm_pkg::PAR_MIN)) begin
      byte_i = int'(a) >> (3 - int'(s));
      off_i = (int'(a) & ((8 >> s) - 1)) << s;
    end else begin
      byte_i = int'(a) << (int'(s) - 3);
    end
    l.row = RW'(byte_i >> 2);
    l.lane = 2'(byte_i);
    l.off = 3'(off_i);
    return l;
  endfunction : ebrm_map

  // Spread a user word over a row: mask in [2*DW-1:DW], data in [DW-1:0]
  function automatic logic [2*DW-1:0] ebrm_place(logic [DW-1:0] d, logic [2:0] s, logic par,
                                                 ebrm_pkg::ebrm_loc_t l);
    logic [DW-1:0] mk;
    logic [DW-1:0] dt;
    int k;
    mk = '0;
    dt = '0;
    for (int j = 0; j < DW; j++) begin
      k = ebrm_idx(j, s, par, l);
      if (j < ebrm_width(s, par) && k < DW) begin
        mk[k] = 1'b1;
        dt[k] = d[j];
      end
    end
    return {mk, dt};
  endfunction : ebrm_place

  // Gather a user word back out of a row; unused bits read zero
  function automatic logic [DW-1:0] ebrm_pick(logic [DW-1:0] line, logic [2:0] s, logic par,
                                              ebrm_pkg::ebrm_loc_t l);
    logic [DW-1:0] q;
    int k;
    q = '0;
    for (int j = 0; j < DW; j++) begin
      k = ebrm_idx(j, s, par, l);
      if (j < ebrm_width(s, par) && k < DW) begin
        q[j] = line[k];
      end
    end
    return q;
  endfunction : ebrm_pick

  // Port shape legal for the mode's width limit; parity only at byte width or wider
  function automatic logic ebrm_shape_ok(logic [2:0] s, logic par, int smax);
    return (int'(s) <= smax) && (!par || s >= 3'(ebrm_pkg::PAR_MIN));
  endfunction : ebrm_shape_ok

  // Reset release
  logic [1:0] rst_sync_ff;
  logic arst_n;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= ebrm_pkg::SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign arst_n = rst_sync_ff[1] & device_wide_clear_n;

  // Control and status registers
  logic [15:0] ctrl_ff;
  logic conflict_ff;
  logic [31:0] prdata_ff;
  ebrm_pkg::ebrm_mode_t mode;
  logic rdw_new;
  logic mix_new;
  logic [1:0] oreg;
  logic [2:0] shift [2];
  logic [1:0] par;
  logic cfg_ok;
  logic a_ok;
  logic b_ok;
  logic narrow_ok;
  logic same_grp;

  assign mode = ebrm_pkg::ebrm_mode_t'(ctrl_ff[ebrm_pkg::MODE_LSB +: 2]);
  assign rdw_new = ctrl_ff[ebrm_pkg::RDW_NEW_BIT];
  assign mix_new = ctrl_ff[ebrm_pkg::MIX_NEW_BIT];
  assign oreg = {ctrl_ff[ebrm_pkg::OREG_B_BIT], ctrl_ff[ebrm_pkg::OREG_A_BIT]};
  assign shift[0] = ctrl_ff[ebrm_pkg::SHIFT_A_LSB +: 3];
  assign shift[1] = ctrl_ff[ebrm_pkg::SHIFT_B_LSB +: 3];
  assign par = {ctrl_ff[ebrm_pkg::PAR_B_BIT], ctrl_ff[ebrm_pkg::PAR_A_BIT]};

  assign a_ok = ebrm_shape_ok(shift[0], par[0], ebrm_pkg::SHIFT_MAX);
  assign b_ok = ebrm_shape_ok(shift[1], par[1], ebrm_pkg::SHIFT_MAX);
  assign narrow_ok = ebrm_shape_ok(shift[0], par[0], ebrm_pkg::NARROW_MAX) &&
                     ebrm_shape_ok(shift[1], par[1], ebrm_pkg::NARROW_MAX);
  assign same_grp = (par[0] == par[1]) && ((shift[0] >= 3'(ebrm_pkg::PAR_MIN)) ==
                    (shift[1] >= 3'(ebrm_pkg::PAR_MIN)) || !par[0]);

  // Illegal shapes stop all memory operations until fixed
  always_comb begin
    case (mode)
      ebrm_pkg::EBRM_SP: cfg_ok = a_ok;
      ebrm_pkg::EBRM_SDP: cfg_ok = a_ok && b_ok && same_grp;
      ebrm_pkg::EBRM_TDP: cfg_ok = narrow_ok && same_grp;
      ebrm_pkg::EBRM_PK: cfg_ok = narrow_ok;
      default: cfg_ok = 1'b0;
    endcase
  end

  // APB decode; zero wait states
  logic sel_ctrl;
  logic sel_stat;
  logic apb_hit;
  logic apb_wr;
  logic [31:0] rd_mux;
  logic conflict_clr;

  assign sel_ctrl = (paddr == ebrm_pkg::CTRL_OFF);
  assign sel_stat = (paddr == ebrm_pkg::STAT_OFF);
  assign apb_hit = sel_ctrl | sel_stat;
  assign apb_wr = psel & penable & pwrite & apb_hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;
  assign prdata = prdata_ff;
  assign conflict_clr = apb_wr & sel_stat & pwdata[ebrm_pkg::CONFLICT_BIT];
  assign rd_mux = sel_ctrl ? {16'h0000, ctrl_ff} :
                  sel_stat ? {30'h00000000, conflict_ff, ~cfg_ok} : 32'h00000000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= ebrm_pkg::CTRL_RST;
    end else if (apb_wr && sel_ctrl) begin
      ctrl_ff <= pwdata[15:0];
    end
  end

  // Read data is captured in the setup cycle so it stands through access
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_ff <= rd_mux;
    end
  end

  // Port gathering
  logic [1:0] ce;
  logic [1:0] we;
  logic [1:0] re;
  logic [1:0] stall;
  logic [1:0] aclr;
  logic [AW-1:0] addr [2];
  logic [DW-1:0] din [2];
  logic [DW-1:0] q [2];
  logic [1:0] wr_allow;
  logic [1:0] rd_allow;
  logic [1:0] go_w;
  logic [1:0] go_r;
  logic [1:0] clr_n;
  ebrm_pkg::ebrm_loc_t loc [2];
  logic [DW-1:0] wm [2];
  logic [DW-1:0] wd [2];

  assign ce = {ce_b, ce_a};
  assign we = {we_b, we_a};
  assign re = {re_b, re_a};
  assign stall = {stall_b, stall_a};
  assign aclr = {aclr_b, aclr_a};
  assign addr[0] = addr_a;
  assign addr[1] = addr_b;
  assign din[0] = din_a;
  assign din[1] = din_b;
  assign q_a = q[0];
  assign q_b = q[1];

  // Port A writes in every mode; in simple dual-port B only reads
  assign wr_allow[0] = 1'b1;
  assign wr_allow[1] = (mode == ebrm_pkg::EBRM_TDP) || (mode == ebrm_pkg::EBRM_PK);
  assign rd_allow[0] = (mode != ebrm_pkg::EBRM_SDP);
  assign rd_allow[1] = (mode != ebrm_pkg::EBRM_SP);

  ebrm_mem_if #(.RW(RW), .DW(DW)) mi ();

  ebrm_mem #(.RW(RW), .DW(DW)) u_mem (
    .clk(core_clk),
    .m(mi.mem)
  );

  // Two writes hitting one bit of one row are flagged, not resolved
  logic both_hit;

  assign both_hit = go_w[0] && go_w[1] && (loc[0].row == loc[1].row) &&
                    ((wm[0] & wm[1]) != '0);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conflict_ff <= 1'b0;
    end else if (both_hit) begin
      conflict_ff <= 1'b1;
    end else if (conflict_clr) begin
      conflict_ff <= 1'b0;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int O = 1 - p;
    logic [AW-1:0] addr_ff;
    logic [AW-1:0] eff;
    ebrm_pkg::ebrm_loc_t raw;
    ebrm_pkg::ebrm_loc_t lane_ff;
    logic [2*DW-1:0] placed;
    logic self_new;
    logic cross_new;
    logic [DW-1:0] ov_m;
    logic [DW-1:0] ov_d;
    logic [DW-1:0] ov_m_ff;
    logic [DW-1:0] ov_d_ff;
    logic [DW-1:0] line;
    logic [DW-1:0] q_lat;
    logic [DW-1:0] qo_ff;

    assign clr_n[p] = arst_n & ~aclr[p];
    assign go_w[p] = ce[p] & we[p] & wr_allow[p] & cfg_ok;
    assign go_r[p] = ce[p] & re[p] & rd_allow[p] & cfg_ok;

    // Stall recirculates the held address instead of the new one
    assign eff = stall[p] ? addr_ff : addr[p];

    // Read-address register: cleared by clr_n, like the bypass and lane registers
    always_ff @(posedge core_clk or negedge clr_n[p]) begin
      if (!clr_n[p]) begin
        addr_ff <= '0;
      end else if (ce[p]) begin
        addr_ff <= eff;
      end
    end

    // Packed halves: port index picks the upper or lower half of the rows
    assign raw = ebrm_map(eff, shift[p]);
    always_comb begin
      loc[p] = raw;
      if (mode == ebrm_pkg::EBRM_PK) begin
        loc[p].row[RW-1] = 1'(p);
      end
    end

    assign placed = ebrm_place(din[p], shift[p], par[p], loc[p]);
    assign wm[p] = placed[2*DW-1:DW];
    assign wd[p] = placed[DW-1:0];

    // Same-port new data, or cross-port new data in true dual-port
    assign self_new = rdw_new & go_w[p] & (mode != ebrm_pkg::EBRM_SDP);
    assign cross_new = mix_new & (mode == ebrm_pkg::EBRM_TDP) & go_w[O] &
                       (loc[O].row == loc[p].row);
    assign ov_m = (self_new ? wm[p] : '0) | (cross_new ? wm[O] : '0);
    assign ov_d = self_new ? wd[p] : wd[O];

    // Simple dual-port same-address reads fall back to the old word
    always_ff @(posedge core_clk or negedge clr_n[p]) begin
      if (!clr_n[p]) begin
        ov_m_ff <= '0;
        ov_d_ff <= '0;
        lane_ff <= '0;
      end else if (go_r[p]) begin
        ov_m_ff <= ov_m;
        ov_d_ff <= ov_d;
        lane_ff <= loc[p];
      end
    end

    assign line = (mi.rline[p] & ~ov_m_ff) | (ov_d_ff & ov_m_ff);
    assign q_lat = ebrm_pick(line, shift[p], par[p], lane_ff);

    always_ff @(posedge core_clk or negedge clr_n[p]) begin
      if (!clr_n[p]) begin
        qo_ff <= '0;
      end else if (ce[p] && oreg[p]) begin
        qo_ff <= q_lat;
      end
    end

    assign q[p] = oreg[p] ? qo_ff : q_lat;

    assign mi.ce[p] = ce[p];
    assign mi.we[p] = go_w[p];
    assign mi.re[p] = go_r[p];
    assign mi.aclr_n[p] = clr_n[p];
    assign mi.row[p] = loc[p].row;
    assign mi.wmask[p] = wm[p];
    assign mi.wdata[p] = wd[p];
  end
endmodule : ebrm_top

// file: inc/ebrm_pkg.sv
// Purpose: Shared constants and types for the embedded block RAM
// Assumes: One core clock; registers reached over APB
// Notes: Notes on behaviour below
package ebrm_pkg;
  localparam int AW = 13;
  localparam int DW = 36;
  localparam int RW = 8;
  localparam int LW = 9;
  localparam int NLANE = 4;
  localparam int SHIFT_MAX = 5;
  localparam int NARROW_MAX = 4;
  localparam int PAR_MIN = 3;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam int MODE_LSB = 0;
  localparam int RDW_NEW_BIT = 2;
  localparam int MIX_NEW_BIT = 3;
  localparam int OREG_A_BIT = 4;
  localparam int OREG_B_BIT = 5;
  localparam int SHIFT_A_LSB = 8;
  localparam int PAR_A_BIT = 11;
  localparam int SHIFT_B_LSB = 12;
  localparam int PAR_B_BIT = 15;
  localparam logic [15:0] CTRL_RST = 16'h3300;
  localparam int CFG_ERR_BIT = 0;
  localparam int CONFLICT_BIT = 1;
  localparam logic [1:0] SYNC_RST = 2'h0;
  typedef enum logic [1:0] {
    EBRM_SP,
    EBRM_SDP,
    EBRM_TDP,
    EBRM_PK
  } ebrm_mode_t;
  typedef struct packed {
    logic [RW-1:0] row;
    logic [1:0] lane;
    logic [2:0] off;
  } ebrm_loc_t;
endpackage : ebrm_pkg

// file: inc/ebrm_mem_if.sv
// Purpose: Carrier between port logic and the storage array
// Assumes: Index 0 is port A, index 1 is port B
// Notes: Masks are per bit of a 36-bit row
`timescale 1ns/1ps
interface ebrm_mem_if #(
  parameter int RW = ebrm_pkg::RW,
  parameter int DW = ebrm_pkg::DW
);
  logic [1:0] ce;
  logic [1:0] we;
  logic [1:0] re;
  logic [1:0] aclr_n;
  logic [RW-1:0] row [2];
  logic [DW-1:0] wmask [2];
  logic [DW-1:0] wdata [2];
  logic [DW-1:0] rline [2];
  modport ctl (output ce, we, re, aclr_n, row, wmask, wdata, input rline);
  modport mem (input ce, we, re, aclr_n, row, wmask, wdata, output rline);
endinterface : ebrm_mem_if

// file: core/ebrm_mem.sv
// Purpose: Two-port bit-maskable storage array with read latches
// Assumes: Both ports on one clock, gated by per-port enables
// Notes: Contents are never cleared; only the read latches are
`timescale 1ns/1ps
module ebrm_mem #(
  parameter int RW = ebrm_pkg::RW,
  parameter int DW = ebrm_pkg::DW
) (
  // Clock
  input wire logic clk,
  // Port side
  ebrm_mem_if.mem m
);
  logic [DW-1:0] store_ff [2**RW];

  // Port B is applied last, so port B wins a same-bit double write
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (m.ce[p] && m.we[p]) begin
        for (int i = 0; i < DW; i++) begin
          if (m.wmask[p][i]) begin
            store_ff[m.row[p]][i] <= m.wdata[p][i];
          end
        end
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_rd
    logic [DW-1:0] rline_ff;
    // Latch holds last read; old word is what the array held before the edge
    always_ff @(posedge clk or negedge m.aclr_n[p]) begin
      if (!m.aclr_n[p]) begin
        rline_ff <= '0;
      end else if (m.ce[p] && m.re[p]) begin
        rline_ff <= store_ff[m.row[p]];
      end
    end
    assign m.rline[p] = rline_ff;
  end
endmodule : ebrm_mem

// file: dv/ebrm_top_properties.sv
// Purpose: Port-level checks for the block RAM top
// Assumes: A shadow of the control word follows APB writes
// Notes: Only top-level ports are watched
`timescale 1ns/1ps
module ebrm_top_properties (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic device_wide_clear_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Ports
  input wire logic ce_a,
  input wire logic re_a,
  input wire logic aclr_a,
  input wire logic [35:0] q_a,
  input wire logic ce_b,
  input wire logic re_b,
  input wire logic aclr_b,
  input wire logic [35:0] q_b
);
  logic [15:0] ctrl_ff;
  wire apb_wr = psel && penable && pwrite;
  // A config write may reshape q at once, so such cycles are left out
  wire calm = device_wide_clear_n && !apb_wr;
  wire oreg_a = ctrl_ff[ebrm_pkg::OREG_A_BIT];
  wire oreg_b = ctrl_ff[ebrm_pkg::OREG_B_BIT];

  always_ff @(posedge core_clk or negedge rst_b or negedge device_wide_clear_n) begin
    if (!rst_b || !device_wide_clear_n) begin
      ctrl_ff <= ebrm_pkg::CTRL_RST;
    end else if (apb_wr && paddr == ebrm_pkg::CTRL_OFF) begin
      ctrl_ff <= pwdata[15:0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_clr_zero_a: assert property (aclr_a |-> q_a == 36'h0)
    else $error("q_a not zero while cleared");
  a_clr_zero_b: assert property (aclr_b |-> q_b == 36'h0)
    else $error("q_b not zero while cleared");
  a_dev_clear: assert property (!device_wide_clear_n |-> q_a == 36'h0 && q_b == 36'h0)
    else $error("outputs not zero under device clear");
  a_gated_hold_a: assert property (!ce_a && !aclr_a && calm |=>
    $stable(q_a) || aclr_a || !device_wide_clear_n) else $error("q_a moved on gated edge");
  a_gated_hold_b: assert property (!ce_b && !aclr_b && calm |=>
    $stable(q_b) || aclr_b || !device_wide_clear_n) else $error("q_b moved on gated edge");
  a_noread_hold_a: assert property (ce_a && !re_a && !oreg_a && !aclr_a && calm |=>
    $stable(q_a) || aclr_a || !device_wide_clear_n) else $error("q_a moved without read");
  a_noread_hold_b: assert property (ce_b && !re_b && !oreg_b && !aclr_b && calm |=>
    $stable(q_b) || aclr_b || !device_wide_clear_n) else $error("q_b moved without read");
  a_oreg_delay_a: assert property (oreg_a && ce_a && re_a && !aclr_a && calm
    && $past(ce_a && !re_a && !aclr_a && calm) |=> $stable(q_a) || aclr_a || !device_wide_clear_n)
    else $error("registered q_a showed read data too early");

  c_oreg_read: cover property (oreg_a && ce_a && re_a);
  c_clear_a: cover property (aclr_a);
  c_both_read: cover property (ce_a && re_a && ce_b && re_b);
  c_packed_pair: cover property (ctrl_ff[ebrm_pkg::MODE_LSB +: 2] == 2'h3 && ce_a && ce_b);
endmodule : ebrm_top_properties

bind ebrm_top ebrm_top_properties u_ebrm_top_properties (.core_clk, .rst_b, .device_wide_clear_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .ce_a, .re_a, .aclr_a, .q_a, .ce_b, .re_b, .aclr_b,
  .q_b);

// file: dv/ebrm_user_port.sv
// Purpose: User logic driving one memory port
// Assumes: Requests change just after a rising edge
// Notes: Idle cycles invert address and data, so stray sampling shows
`timescale 1ns/1ps
module ebrm_user_port (
  // Clock
  input wire logic clk,
  // Memory port
  output logic ce = 1'b0,
  output logic we = 1'b0,
  output logic re = 1'b0,
  output logic stall = 1'b0,
  output logic aclr = 1'b0,
  output logic [12:0] addr = 13'h0,
  output logic [35:0] din = 36'h0
);
  task cyc(input logic c, w, r, s, input logic [12:0] a, input logic [35:0] d);
    @(posedge clk);
    ce <= c;
    we <= w;
    re <= r;
    stall <= s;
    addr <= a;
    din <= d;
  endtask : cyc

  task idle;
    cyc(1'b0, 1'b0, 1'b0, 1'b0, ~addr, ~din);
  endtask : idle

  // Clear only with reads stopped; it zeroes latches and registers, never contents
  task clr(input logic v);
    cyc(1'b0, 1'b0, 1'b0, 1'b0, addr, din);
    aclr <= v;
  endtask : clr
endmodule : ebrm_user_port

// file: dv/embedded_block_ram_modes_bench.sv
// Purpose: Self-checking bench for the block RAM top
// Assumes: Both ports stay x8 for every data check, so one byte model serves every mode
// Notes: Expected bytes come from an associative model
`timescale 1ns/1ps
module embedded_block_ram_modes_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic device_wide_clear_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic ce_a, we_a, re_a, stall_a, aclr_a, ce_b, we_b, re_b, stall_b, aclr_b;
  logic [12:0] addr_a, addr_b;
  logic [35:0] din_a, din_b, q_a, q_b;
  logic [35:0] dv [2];
  logic [7:0] mem [int];
  logic [7:0] old;
  int fails = 0;
  int checks = 0;

  always #2 core_clk = ~core_clk;

  ebrm_top u_ebrm_top (.core_clk, .rst_b, .device_wide_clear_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ce_a, .addr_a, .din_a, .we_a, .re_a, .stall_a, .aclr_a,
    .q_a, .ce_b, .addr_b, .din_b, .we_b, .re_b, .stall_b, .aclr_b, .q_b);
  ebrm_user_port u_ebrm_user_port_a (.clk(core_clk), .ce(ce_a), .we(we_a), .re(re_a),
    .stall(stall_a), .aclr(aclr_a), .addr(addr_a), .din(din_a));
  ebrm_user_port u_ebrm_user_port_b (.clk(core_clk), .ce(ce_b), .we(we_b), .re(re_b),
    .stall(stall_b), .aclr(aclr_b), .addr(addr_b), .din(din_b));

  task check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic op(input logic p, c, w, r, s, input int a);
    dv[p] = {4'($urandom), $urandom};
    if (p) u_ebrm_user_port_b.cyc(c, w, r, s, 13'(a), dv[p]);
    else u_ebrm_user_port_a.cyc(c, w, r, s, 13'(a), dv[p]);
  endtask : op

  task step;
    fork
      u_ebrm_user_port_a.idle;
      u_ebrm_user_port_b.idle;
    join
    #1;
  endtask : step

  task chk(input logic p, input logic [7:0] v);
    check(p ? "q_b" : "q_a", {28'h0, p ? q_b[7:0] : q_a[7:0]}, {28'h0, v});
  endtask : chk

  task rd_chk(input logic p, input int a);
    op(p, 1'b1, 1'b0, 1'b1, 1'b0, a);
    step;
    chk(p, mem[a]);
  endtask : rd_chk

  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    final_report;
  end

  initial begin
    void'($urandom(32'h8b0b));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("q_a", q_a, 36'h0);
    check("q_b", q_b, 36'h0);
    apb(1'b0, ebrm_pkg::CTRL_OFF, 32'h0);
    check("ctrl", {4'h0, rd}, {20'h0, ebrm_pkg::CTRL_RST});
    apb(1'b1, 12'h010, 32'hffff);
    check("pslverr", {35'h0, err}, 36'h1);
    for (int k = 0; k < 8; k++) begin
      op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, k * 37);
      mem[k * 37] = dv[0][7:0];
    end
    for (int k = 0; k < 8; k++) rd_chk(1'b0, k * 37);
    old = mem[37];
    op(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 37);
    mem[37] = dv[0][7:0];
    step;
    chk(1'b0, old);
    op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 74);
    mem[74] = dv[0][7:0];
    step;
    chk(1'b0, old);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3304);
    op(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 111);
    mem[111] = dv[0][7:0];
    step;
    chk(1'b0, mem[111]);
    op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 148);
    step;
    chk(1'b0, mem[111]);
    rd_chk(1'b0, 148);
    // Stalled address stays 148 while 185 is shown
    op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 185);
    mem[148] = dv[0][7:0];
    step;
    chk(1'b0, mem[148]);
    rd_chk(1'b0, 185);
    fork
      u_ebrm_user_port_a.clr(1'b1);
      u_ebrm_user_port_b.clr(1'b1);
    join
    #1;
    check("q_a", q_a, 36'h0);
    check("q_b", q_b, 36'h0);
    fork
      u_ebrm_user_port_a.clr(1'b0);
      u_ebrm_user_port_b.clr(1'b0);
    join
    op(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 37);
    step;
    chk(1'b0, mem[0]);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3314);
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 0);
    op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 74);
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 74);
    #1;
    chk(1'b0, mem[0]);
    step;
    chk(1'b0, mem[74]);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3302);
    old = mem[111];
    // Never two writers on one row
    fork
      op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 111);
      op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 111);
    join
    mem[111] = dv[0][7:0];
    step;
    chk(1'b1, old);
    rd_chk(1'b1, 111);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h330a);
    old = mem[148];
    fork
      op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 148);
      op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 148);
    join
    mem[148] = dv[1][7:0];
    step;
    chk(1'b0, mem[148]);
    chk(1'b1, old);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3301);
    fork
      op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 185);
      op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 37);
    join
    mem[185] = dv[0][7:0];
    step;
    chk(1'b1, mem[37]);
    old = mem[0];
    fork
      op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 0);
      op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    join
    mem[0] = dv[0][7:0];
    step;
    chk(1'b1, old);
    op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 185);
    step;
    chk(1'b1, old);
    rd_chk(1'b1, 185);
    // Packed halves: one address, two separate words
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3303);
    fork
      op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 37);
      op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 37);
    join
    mem[37] = dv[0][7:0];
    old = dv[1][7:0];
    step;
    rd_chk(1'b0, 37);
    op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 37);
    step;
    chk(1'b1, old);
    apb(1'b0, ebrm_pkg::STAT_OFF, 32'h0);
    check("status", {4'h0, rd}, 36'h0);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3502);
    apb(1'b0, ebrm_pkg::STAT_OFF, 32'h0);
    check("status", {4'h0, rd}, 36'h1);
    apb(1'b1, ebrm_pkg::CTRL_OFF, 32'h3b01);
    apb(1'b0, ebrm_pkg::STAT_OFF, 32'h0);
    check("status", {4'h0, rd}, 36'h1);
    @(posedge core_clk);
    device_wide_clear_n <= 1'b0;
    #1;
    check("q_a", q_a, 36'h0);
    check("q_b", q_b, 36'h0);
    @(posedge core_clk);
    device_wide_clear_n <= 1'b1;
    apb(1'b0, ebrm_pkg::CTRL_OFF, 32'h0);
    check("ctrl", {4'h0, rd}, {20'h0, ebrm_pkg::CTRL_RST});
    final_report;
  end
endmodule : embedded_block_ram_modes_bench
